/* File: hw/crf_addr_map.sv */
/*
 * Address formation for one data access: bank selection for direct
 * operands and resolution of the pointer-zero indirect locations.
 * Assumes the core presents the direct operand address and the access bit.
 */
`timescale 1ns/100ps
`default_nettype none
module crf_addr_map
   import crf_pkg::*;
(
   // Direct operand.
   input  wire logic [7:0]          i_operand,
   input  wire logic                i_use_bank,
   input  wire logic [3:0]          i_bank,
   // Pointer state.
   input  wire logic [11:0]         i_ptr0,
   input  wire logic [7:0]          i_working,
   // Result.
   output logic [11:0]              o_direct_addr,
   output crf_pkg::crf_ptr_mode_t   o_mode,
   output logic [11:0]              o_indirect_addr
);
   always_comb begin
      // Quick-access upper half maps to the top bank only at and above the split,
      // so F16h..F5Fh always needs the bank register.
      if (i_use_bank) begin
         o_direct_addr = {i_bank, i_operand};
      end else if (i_operand >= ACCESS_SPLIT) begin
         o_direct_addr = {ACCESS_SFR_BANK, i_operand};
      end else begin
         o_direct_addr = {4'h0, i_operand};
      end
   end

   always_comb begin
      case (o_direct_addr)
         ADDR_PTR0_PLAIN:   o_mode = CRF_PM_PLAIN;
         ADDR_PTR0_POSTINC: o_mode = CRF_PM_POSTINC;
         ADDR_PTR0_POSTDEC: o_mode = CRF_PM_POSTDEC;
         ADDR_PTR0_PREINC:  o_mode = CRF_PM_PREINC;
         ADDR_PTR0_OFFSET:  o_mode = CRF_PM_OFFSET;
         default:           o_mode = CRF_PM_NONE;
      endcase
   end

   always_comb begin
      case (o_mode)
         CRF_PM_PREINC: o_indirect_addr = i_ptr0 + 12'h001;
         CRF_PM_OFFSET: o_indirect_addr = i_ptr0 + {4'h0, i_working};
         default:       o_indirect_addr = i_ptr0;
      endcase
   end
endmodule // crf_addr_map
`default_nettype wire

/* File: hw/crf_core_regs.sv */
/*
 * Core special-register file with pointer-zero indirect access.
 * Assumes one data access per cycle from the core; general data memory lies
 * outside and is reached through the o_mem_* port, read data combinational.
 */
// Summary of operation
// - Unimplemented locations read zero, ignore writes.
// - F16h..F5Fh reachable only through banked addressing.
// - Indirect locations redirect to pointer-addressed memory.
// - Offset location addresses pointer plus working register.
// - Pointer zero twelve bits, high nibble only.
// - Footnoted bit exists only with master clear off.
// - Small-flash variants read footnoted bits as zero.
// - Low pin-count variants read missing registers zero.
`timescale 1ns/100ps
`default_nettype none
module crf_core_regs
   import crf_pkg::*;
(
   // Clock and reset.
   input  wire logic        i_clock,
   input  wire logic        i_arst_n,
   // Variant straps.
   input  wire logic        i_small_flash,
   input  wire logic        i_low_pin,
   input  wire logic        i_mclr_enabled,
   // Core data access.
   input  wire logic        i_acc_valid,
   input  wire logic        i_acc_write,
   input  wire logic [7:0]  i_acc_operand,
   input  wire logic        i_acc_use_bank,
   input  wire logic [3:0]  i_bank_select,
   input  wire logic [7:0]  i_acc_wdata,
   output logic [7:0]       o_acc_rdata,
   output logic             o_acc_rvalid,
   // External data memory.
   output logic             o_mem_valid,
   output logic             o_mem_write,
   output logic [11:0]      o_mem_addr,
   output logic [7:0]       o_mem_wdata,
   input  wire logic [7:0]  i_mem_rdata,
   // Register contents for the core.
   output logic [7:0]       o_working,
   output logic [11:0]      o_ptr0
);
   import crf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Address formation.

   logic [11:0]   direct_addr;
   logic [11:0]   indirect_addr;
   crf_ptr_mode_t ptr_mode;
   logic [7:0]    read_mask;
   logic          is_indirect;
   logic [11:0]   ptr0_reg;

   crf_addr_map u_map (
      .i_operand       (i_acc_operand),
      .i_use_bank      (i_acc_use_bank),
      .i_bank          (i_bank_select),
      .i_ptr0          (ptr0_reg),
      .i_working       (o_working),
      .o_direct_addr   (direct_addr),
      .o_mode          (ptr_mode),
      .o_indirect_addr (indirect_addr)
   );

   crf_variant_mask u_mask (
      .i_small_flash  (i_small_flash),
      .i_low_pin      (i_low_pin),
      .i_mclr_enabled (i_mclr_enabled),
      .i_addr         (direct_addr),
      .o_mask         (read_mask)
   );

   assign is_indirect = (ptr_mode != CRF_PM_NONE);

   ////////////////////////////////////////////////////////////////////////////
   // Storage.

   logic [7:0] regs [ADDR_INT_CTRL3:ADDR_STACK_TOP_UPPER];
   logic       reg_hit;
   logic       wr_reg;

   function automatic logic [7:0] field_mask(input logic [11:0] a);
      case (a)
         ADDR_PTR0_HIGH:       field_mask = MASK_PTR0_HIGH;
         ADDR_TABLE_PTR_UPPER: field_mask = MASK_TABLE_UPPER;
         ADDR_PC_LATCH_UPPER:  field_mask = MASK_UPPER5;
         ADDR_STACK_TOP_UPPER: field_mask = MASK_UPPER5;
         ADDR_STACK_PTR:       field_mask = MASK_STACK_PTR;
         default:              field_mask = 8'hff;
      endcase
   endfunction

   assign reg_hit = (direct_addr >= ADDR_INT_CTRL3);
   assign wr_reg  = i_acc_valid && i_acc_write && !is_indirect;

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int k = int'(ADDR_INT_CTRL3); k <= int'(ADDR_STACK_TOP_UPPER); k++) begin
            regs[k] <= RST_ZERO;
         end
         regs[ADDR_INT_CTRL3] <= RST_INT_CTRL3;
         regs[ADDR_INT_CTRL2] <= RST_INT_CTRL2;
      end else if (wr_reg && reg_hit) begin
         regs[direct_addr] <= i_acc_wdata & field_mask(direct_addr);
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_working <= RST_ZERO;
      end else if (wr_reg && direct_addr == ADDR_WORKING) begin
         o_working <= i_acc_wdata;
      end
   end

   // Pointer zero: direct writes to either half, or step on post-increment, post-decrement or pre-increment use.
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ptr0_reg <= 12'h000;
      end else if (wr_reg && direct_addr == ADDR_PTR0_LOW) begin
         ptr0_reg[7:0] <= i_acc_wdata;
      end else if (wr_reg && direct_addr == ADDR_PTR0_HIGH) begin
         ptr0_reg[11:8] <= i_acc_wdata[3:0];
      end else if (i_acc_valid) begin
         case (ptr_mode)
            CRF_PM_POSTINC: ptr0_reg <= ptr0_reg + 12'h001;
            CRF_PM_POSTDEC: ptr0_reg <= ptr0_reg - 12'h001;
            CRF_PM_PREINC:  ptr0_reg <= indirect_addr;
            default:        ptr0_reg <= ptr0_reg;
         endcase
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_ptr0 <= 12'h000;
      end else begin
         o_ptr0 <= ptr0_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory port and read data. Indirect and ordinary memory accesses go out;
   // the answer is registered one cycle after the request.

   logic [7:0] rdata_next;
   logic       mem_sel;

   // Addresses below the special region and indirect targets go to memory.
   assign mem_sel = is_indirect || direct_addr < BANKED_SFR_LO;

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_mem_valid <= 1'b0;
         o_mem_write <= 1'b0;
         o_mem_addr  <= 12'h000;
         o_mem_wdata <= RST_ZERO;
      end else begin
         o_mem_valid <= i_acc_valid && mem_sel;
         o_mem_write <= i_acc_write;
         o_mem_addr  <= is_indirect ? indirect_addr : direct_addr;
         o_mem_wdata <= i_acc_wdata;
      end
   end

   // Pending read that must take its data from memory next cycle.
   logic pend_mem_rd;
   logic [7:0] reg_rdata_q;

   always_comb begin
      rdata_next = 8'h00;
      if (direct_addr == ADDR_WORKING) begin
         rdata_next = o_working;
      end else if (direct_addr == ADDR_PTR0_LOW) begin
         rdata_next = ptr0_reg[7:0];
      end else if (direct_addr == ADDR_PTR0_HIGH) begin
         rdata_next = {4'h0, ptr0_reg[11:8]};
      end else if (reg_hit) begin
         rdata_next = regs[direct_addr];
      end
      rdata_next = rdata_next & read_mask;
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pend_mem_rd <= 1'b0;
         reg_rdata_q <= RST_ZERO;
      end else begin
         pend_mem_rd <= i_acc_valid && !i_acc_write && mem_sel;
         reg_rdata_q <= rdata_next;
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_acc_rvalid <= 1'b0;
      end else begin
         o_acc_rvalid <= i_acc_valid && !i_acc_write;
      end
   end

   // Memory data is combinational on the registered address, so the answer
   // is steered at the output flop: register data or memory data.
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_acc_rdata <= RST_ZERO;
      end else begin
         o_acc_rdata <= pend_mem_rd ? i_mem_rdata : reg_rdata_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence postinc_use_s;
      i_acc_valid && ptr_mode == CRF_PM_POSTINC && !wr_reg;
   endsequence

   sequence postdec_use_s;
      i_acc_valid && ptr_mode == CRF_PM_POSTDEC;
   endsequence

   ptr_postinc_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      postinc_use_s |=> ptr0_reg == $past(ptr0_reg) + 12'h001)
      else $error("pointer did not step up after use");

   ptr_postdec_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      postdec_use_s |=> ptr0_reg == $past(ptr0_reg) - 12'h001)
      else $error("pointer did not step down after use");

   ptr_plain_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && ptr_mode == CRF_PM_PLAIN |=> $stable(ptr0_reg))
      else $error("plain access moved the pointer");

   offset_addr_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && ptr_mode == CRF_PM_OFFSET
      |=> o_mem_valid && o_mem_addr == $past(ptr0_reg) + {4'h0, $past(o_working)})
      else $error("offset access used the wrong address");

   indirect_out_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && is_indirect |=> o_mem_valid)
      else $error("indirect access not sent to memory");

   unimpl_read_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && !i_acc_write && !mem_sel && !reg_hit
      && direct_addr != ADDR_WORKING && direct_addr != ADDR_PTR0_LOW
      && direct_addr != ADDR_PTR0_HIGH |=> ##1 o_acc_rdata == 8'h00)
      else $error("unimplemented location read nonzero");

   ptr_high_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && !i_acc_write && direct_addr == ADDR_PTR0_HIGH
      |=> ##1 o_acc_rdata[7:4] == 4'h0)
      else $error("pointer high upper nibble not zero");

   banked_only_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      !i_acc_use_bank |-> !(direct_addr >= BANKED_SFR_LO && direct_addr <= BANKED_SFR_HI))
      else $error("banked-only register reached without bank");

   mclr_bit_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && !i_acc_write && direct_addr == ADDR_INT_CTRL && i_mclr_enabled
      |=> ##1 o_acc_rdata[CHANGE_FLAG_POS] == 1'b0)
      else $error("master clear bit visible while enabled");

   small_flash_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && !i_acc_write && direct_addr == ADDR_TABLE_PTR_UPPER && i_small_flash
      |=> ##1 o_acc_rdata[TABLE_BIT21_POS] == 1'b0)
      else $error("absent table bit read nonzero");

   low_pin_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && !i_acc_write && i_low_pin && !is_indirect
      && direct_addr >= BANKED_SFR_LO && direct_addr <= BANKED_SFR_HI
      |=> ##1 o_acc_rdata == 8'h00)
      else $error("missing register read nonzero on low pin variant");

   sequence ind_read_s;
      i_acc_valid && is_indirect && !i_acc_write;
   endsequence

   sequence ind_write_s;
      i_acc_valid && is_indirect && i_acc_write;
   endsequence

   ptr_preinc_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && ptr_mode == CRF_PM_PREINC |=> ptr0_reg == $past(ptr0_reg) + 12'h001)
      else $error("pointer did not step up before use");

   preinc_addr_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && ptr_mode == CRF_PM_PREINC
      |=> o_mem_addr == $past(ptr0_reg) + 12'h001)
      else $error("pre-increment access used the old pointer");

   offset_keep_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && ptr_mode == CRF_PM_OFFSET |=> $stable(ptr0_reg))
      else $error("offset access moved the pointer");

   plain_addr_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && (ptr_mode == CRF_PM_PLAIN || ptr_mode == CRF_PM_POSTINC
      || ptr_mode == CRF_PM_POSTDEC) |=> o_mem_addr == $past(ptr0_reg))
      else $error("indirect access used the wrong address");

   ind_rdata_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      ind_read_s |=> ##1 o_acc_rdata == $past(i_mem_rdata))
      else $error("indirect read did not return memory data");

   ind_wdata_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      ind_write_s |=> o_mem_valid && o_mem_write && o_mem_wdata == $past(i_acc_wdata))
      else $error("indirect write not passed to memory");

   unimpl_write_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && i_acc_write && !mem_sel && !reg_hit
      && direct_addr != ADDR_WORKING && direct_addr != ADDR_PTR0_LOW
      && direct_addr != ADDR_PTR0_HIGH
      |=> !o_mem_valid && $stable(o_working) && $stable(ptr0_reg))
      else $error("write to unimplemented location took effect");

   ptr_low_wr_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && i_acc_write && direct_addr == ADDR_PTR0_LOW
      |=> ptr0_reg[7:0] == $past(i_acc_wdata) && ptr0_reg[11:8] == $past(ptr0_reg[11:8]))
      else $error("pointer low write wrong");

   ptr_high_wr_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && i_acc_write && direct_addr == ADDR_PTR0_HIGH
      |=> ptr0_reg[11:8] == $past(i_acc_wdata[3:0]) && ptr0_reg[7:0] == $past(ptr0_reg[7:0]))
      else $error("pointer high write wrong");

   quick_low_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      !i_acc_use_bank && i_acc_operand < ACCESS_SPLIT |-> direct_addr[11:8] == 4'h0)
      else $error("quick-access low half left bank zero");

   flag_shown_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && !i_acc_write && direct_addr == ADDR_INT_CTRL && !i_mclr_enabled
      |=> ##1 o_acc_rdata == $past(regs[ADDR_INT_CTRL], 2))
      else $error("change flag hidden while master clear is off");

   large_flash_a: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      i_acc_valid && !i_acc_write && direct_addr == ADDR_TABLE_PTR_UPPER && !i_small_flash
      |=> ##1 o_acc_rdata == $past(regs[ADDR_TABLE_PTR_UPPER], 2))
      else $error("table pointer upper byte read wrong");

endmodule // crf_core_regs
`default_nettype wire

/* File: hw/crf_pkg.sv */
/*
 * Package for the core register file: register addresses, field layouts,
 * reset values and pointer-access modes.
 * Assumes a 12-bit data address space and 8-bit data.
 */
package crf_pkg;
   localparam int          AW = 12;
   localparam int          DW = 8;
   // Register addresses.
   localparam logic [11:0] ADDR_INDIRECT_1      = 12'hfe7;
   localparam logic [11:0] ADDR_WORKING         = 12'hfe8;
   localparam logic [11:0] ADDR_PTR0_LOW        = 12'hfe9;
   localparam logic [11:0] ADDR_PTR0_HIGH       = 12'hfea;
   localparam logic [11:0] ADDR_PTR0_OFFSET     = 12'hfeb;
   localparam logic [11:0] ADDR_PTR0_PREINC     = 12'hfec;
   localparam logic [11:0] ADDR_PTR0_POSTDEC    = 12'hfed;
   localparam logic [11:0] ADDR_PTR0_POSTINC    = 12'hfee;
   localparam logic [11:0] ADDR_PTR0_PLAIN      = 12'hfef;
   localparam logic [11:0] ADDR_INT_CTRL3       = 12'hff0;
   localparam logic [11:0] ADDR_INT_CTRL2       = 12'hff1;
   localparam logic [11:0] ADDR_INT_CTRL        = 12'hff2;
   localparam logic [11:0] ADDR_PROD_LOW        = 12'hff3;
   localparam logic [11:0] ADDR_PROD_HIGH       = 12'hff4;
   localparam logic [11:0] ADDR_TABLE_LATCH     = 12'hff5;
   localparam logic [11:0] ADDR_TABLE_PTR_LOW   = 12'hff6;
   localparam logic [11:0] ADDR_TABLE_PTR_HIGH  = 12'hff7;
   localparam logic [11:0] ADDR_TABLE_PTR_UPPER = 12'hff8;
   localparam logic [11:0] ADDR_PC_LOW          = 12'hff9;
   localparam logic [11:0] ADDR_PC_LATCH_HIGH   = 12'hffa;
   localparam logic [11:0] ADDR_PC_LATCH_UPPER  = 12'hffb;
   localparam logic [11:0] ADDR_STACK_PTR       = 12'hffc;
   localparam logic [11:0] ADDR_STACK_TOP_LOW   = 12'hffd;
   localparam logic [11:0] ADDR_STACK_TOP_HIGH  = 12'hffe;
   localparam logic [11:0] ADDR_STACK_TOP_UPPER = 12'hfff;
   // Banked-only special register range and quick-access boundary.
   localparam logic [11:0] BANKED_SFR_LO        = 12'hf16;
   localparam logic [11:0] BANKED_SFR_HI        = 12'hf5f;
   localparam logic [7:0]  ACCESS_SPLIT         = 8'h60;
   localparam logic [3:0]  ACCESS_SFR_BANK      = 4'hf;
   // Field masks of the mixed registers.
   localparam logic [7:0]  MASK_PTR0_HIGH       = 8'h0f;
   localparam logic [7:0]  MASK_UPPER5          = 8'h1f;
   localparam logic [7:0]  MASK_TABLE_UPPER     = 8'h3f;
   localparam logic [7:0]  MASK_STACK_PTR       = 8'hdf;
   localparam logic [7:0]  MASK_INT_CTRL3       = 8'hff;
   localparam int          TABLE_BIT21_POS      = 5;
   localparam int          CHANGE_FLAG_POS      = 0;
   // Reset values.
   localparam logic [7:0]  RST_INT_CTRL3        = 8'hc0;
   localparam logic [7:0]  RST_INT_CTRL2        = 8'hff;
   localparam logic [7:0]  RST_ZERO             = 8'h00;
   // Pointer access modes.
   typedef enum logic [2:0] {
      CRF_PM_NONE, CRF_PM_PLAIN, CRF_PM_POSTINC, CRF_PM_POSTDEC,
      CRF_PM_PREINC, CRF_PM_OFFSET
   } crf_ptr_mode_t;
endpackage

/* File: hw/crf_variant_mask.sv */
/*
 * Read mask for variant-dependent bits.
 * Assumes the variant straps are steady after reset.
 */
`timescale 1ns/100ps
`default_nettype none
module crf_variant_mask
   import crf_pkg::*;
(
   // Variant and configuration.
   input  wire logic        i_small_flash,
   input  wire logic        i_low_pin,
   input  wire logic        i_mclr_enabled,
   // Register selected.
   input  wire logic [11:0] i_addr,
   // Mask of readable bits.
   output logic [7:0]       o_mask
);
   always_comb begin
      o_mask = 8'hff;
      // The bit 21 of the table pointer is only present on the larger flash.
      if (i_addr == ADDR_TABLE_PTR_UPPER && i_small_flash) begin
         o_mask[TABLE_BIT21_POS] = 1'b0;
      end
      // The port-B change flag pin doubles as master clear.
      if (i_addr == ADDR_INT_CTRL && i_mclr_enabled) begin
         o_mask[CHANGE_FLAG_POS] = 1'b0;
      end
      if (i_low_pin && i_addr >= BANKED_SFR_LO && i_addr <= BANKED_SFR_HI) begin
         o_mask = 8'h00;
      end
   end
endmodule // crf_variant_mask
`default_nettype wire

/* File: verif/tb.sv */
/*
 * Self-checking testbench for crf_core_regs: reset values, field masks,
 * unimplemented locations, bank routing, pointer-zero indirect access
 * and variant straps.
 * Assumes the registered access timing of the design: valid pulse taken
 * at a rising edge, rvalid and the memory request in the next cycle, and
 * read data one cycle after rvalid.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
   import crf_pkg::*;
   logic        i_clock, i_arst_n, i_small_flash, i_low_pin, i_mclr_enabled;
   logic        i_acc_valid, i_acc_write, i_acc_use_bank;
   logic [7:0]  i_acc_operand, i_acc_wdata, i_mem_rdata;
   logic [3:0]  i_bank_select;
   logic [7:0]  o_acc_rdata, o_mem_wdata, o_working;
   logic        o_acc_rvalid, o_mem_valid, o_mem_write;
   logic [11:0] o_mem_addr, o_ptr0;
   int          n_errors = 0;
   int          checked = 0;
   logic [7:0]  rd, mwd;
   logic        mv, mw;
   logic [11:0] ma;
   // Address in the upper bits, expected value in the low byte.
   logic [19:0] rst_t [11] = '{20'hff0c0, 20'hff1ff, 20'hff500, 20'hff600, 20'hff700,
      20'hff800, 20'hffa00, 20'hffb00, 20'hffd00, 20'hffe00, 20'hfff00};
   logic [19:0] msk_t [10] = '{20'hfea0f, 20'hffb1f, 20'hfff1f, 20'hffcdf, 20'hff83f,
      20'hff1ff, 20'hff4ff, 20'hff3ff, 20'hffeff, 20'hfe9ff};
   logic [11:0] gap_t [7] = '{12'hfe7, 12'hfd0, 12'hfe0, 12'hf60, 12'hf5f, 12'hf16, 12'hf20};

   crf_core_regs crf_core_regs_i (
      .i_clock        (i_clock),
      .i_arst_n       (i_arst_n),
      .i_small_flash  (i_small_flash),
      .i_low_pin      (i_low_pin),
      .i_mclr_enabled (i_mclr_enabled),
      .i_acc_valid    (i_acc_valid),
      .i_acc_write    (i_acc_write),
      .i_acc_operand  (i_acc_operand),
      .i_acc_use_bank (i_acc_use_bank),
      .i_bank_select  (i_bank_select),
      .i_acc_wdata    (i_acc_wdata),
      .o_acc_rdata    (o_acc_rdata),
      .o_acc_rvalid   (o_acc_rvalid),
      .o_mem_valid    (o_mem_valid),
      .o_mem_write    (o_mem_write),
      .o_mem_addr     (o_mem_addr),
      .o_mem_wdata    (o_mem_wdata),
      .i_mem_rdata    (i_mem_rdata),
      .o_working      (o_working),
      .o_ptr0         (o_ptr0)
   );

   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One access, entered at a falling edge; memory data is offered only while
   // the request stands, and inverted afterwards so stale data never matches.
   task automatic acc(input logic wr, input logic [7:0] op, input logic ub,
                      input logic [3:0] bk, input logic [7:0] wd, input logic [7:0] md);
      i_acc_valid = 1'b1;
      i_acc_write = wr;
      i_acc_operand = op;
      i_acc_use_bank = ub;
      i_bank_select = bk;
      i_acc_wdata = wd;
      @(posedge i_clock);
      @(negedge i_clock);
      i_acc_valid = 1'b0;
      // The answer comes at a fixed edge; reads pulse rvalid, writes never do.
      chk("rvalid", {11'h0, ~wr}, {11'h0, o_acc_rvalid});
      mv = o_mem_valid;
      mw = o_mem_write;
      ma = o_mem_addr;
      mwd = o_mem_wdata;
      i_mem_rdata = md;
      @(negedge i_clock);
      i_mem_rdata = ~md;
      rd = o_acc_rdata;
   endtask

   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      acc(1'b1, a[7:0], 1'b1, a[11:8], d, 8'h00);
   endtask

   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] e);
      acc(1'b0, a[7:0], 1'b1, a[11:8], 8'h00, 8'h99);
      chk(nm, {4'h0, e}, {4'h0, rd});
      chk("no_mem_request", 12'h000, {11'h0, mv});
   endtask

   task automatic ind(input logic [7:0] op, input logic wr, input logic [11:0] ea,
                      input logic [11:0] ep);
      acc(wr, op, 1'b0, 4'h0, 8'h77, 8'h3c);
      chk("mem_addr", ea, ma);
      chk("mem_valid", 12'h001, {11'h0, mv});
      chk("mem_write", {11'h0, wr}, {11'h0, mw});
      if (wr)
         chk("mem_wdata", 12'h077, {4'h0, mwd});
      else
         chk("ind_rdata", 12'h03c, {4'h0, rd});
      @(negedge i_clock);
      chk("ptr0", ep, o_ptr0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      i_arst_n = 1'b0;
      i_small_flash = 1'b0;
      i_low_pin = 1'b0;
      i_mclr_enabled = 1'b0;
      i_acc_valid = 1'b0;
      i_acc_write = 1'b0;
      i_acc_operand = 8'h00;
      i_acc_use_bank = 1'b0;
      i_bank_select = 4'h0;
      i_acc_wdata = 8'h00;
      i_mem_rdata = 8'h00;
      repeat (20) @(negedge i_clock);
      i_arst_n = 1'b1;
      chk("working_reset", 12'h000, {4'h0, o_working});
      chk("ptr0_reset", 12'h000, o_ptr0);
      for (int i = 0; i < 11; i++) begin
         rd_chk("reset_value", rst_t[i][19:8], rst_t[i][7:0]);
      end
      $display("test reset_values done");
      for (int i = 0; i < 10; i++) begin
         wr_reg(msk_t[i][19:8], 8'hff);
         rd_chk("field_mask", msk_t[i][19:8], msk_t[i][7:0]);
      end
      $display("test field_masks done");
      for (int i = 0; i < 7; i++) begin
         wr_reg(gap_t[i], 8'ha5);
         rd_chk("unimplemented", gap_t[i], 8'h00);
      end
      acc(1'b0, 8'h20, 1'b0, 4'hf, 8'h00, 8'h5a);
      chk("quick_low_addr", 12'h020, ma);
      chk("quick_low_data", 12'h05a, {4'h0, rd});
      acc(1'b1, 8'h60, 1'b0, 4'h0, 8'h11, 8'h00);
      chk("quick_high_routed", 12'h000, {11'h0, mv});
      acc(1'b1, 8'he8, 1'b0, 4'h0, 8'h5a, 8'h00);
      chk("quick_working", 12'h05a, {4'h0, o_working});
      $display("test unimplemented_and_banks done");
      wr_reg(ADDR_WORKING, 8'h10);
      wr_reg(ADDR_PTR0_LOW, 8'hff);
      wr_reg(ADDR_PTR0_HIGH, 8'hf2);
      ind(8'hef, 1'b0, 12'h2ff, 12'h2ff);
      ind(8'hee, 1'b0, 12'h2ff, 12'h300);
      ind(8'hed, 1'b0, 12'h300, 12'h2ff);
      ind(8'hec, 1'b0, 12'h300, 12'h300);
      ind(8'heb, 1'b0, 12'h310, 12'h300);
      ind(8'hef, 1'b1, 12'h300, 12'h300);
      ind(8'hee, 1'b1, 12'h300, 12'h301);
      rd_chk("ptr_low", ADDR_PTR0_LOW, 8'h01);
      rd_chk("ptr_high", ADDR_PTR0_HIGH, 8'h03);
      wr_reg(ADDR_PTR0_LOW, 8'hff);
      wr_reg(ADDR_PTR0_HIGH, 8'h0f);
      ind(8'hee, 1'b0, 12'hfff, 12'h000);
      $display("test pointer_access done");
      wr_reg(ADDR_INT_CTRL, 8'hff);
      i_mclr_enabled = 1'b1;
      rd_chk("flag_hidden", ADDR_INT_CTRL, 8'hfe);
      i_mclr_enabled = 1'b0;
      rd_chk("flag_shown", ADDR_INT_CTRL, 8'hff);
      wr_reg(ADDR_TABLE_PTR_UPPER, 8'h3f);
      i_small_flash = 1'b1;
      rd_chk("small_flash", ADDR_TABLE_PTR_UPPER, 8'h1f);
      i_small_flash = 1'b0;
      rd_chk("large_flash", ADDR_TABLE_PTR_UPPER, 8'h3f);
      i_low_pin = 1'b1;
      rd_chk("low_pin_gap", 12'hf26, 8'h00);
      rd_chk("low_pin_core", ADDR_INT_CTRL3, 8'hc0);
      i_low_pin = 1'b0;
      $display("test variants done");
      wr_reg(ADDR_PTR0_LOW, 8'h5a);
      i_arst_n = 1'b0;
      repeat (2) @(negedge i_clock);
      i_arst_n = 1'b1;
      rd_chk("second_reset", ADDR_TABLE_PTR_UPPER, 8'h00);
      chk("second_reset_ptr0", 12'h000, o_ptr0);
      chk("second_reset_working", 12'h000, {4'h0, o_working});
      $display("test second_reset done");
      summarize;
   end

   // About 180 cycles are needed; over twenty times that means a hang.
   initial begin
      repeat (4000) @(posedge i_clock);
      n_errors++;
      summarize;
   end
endmodule // tb
`default_nettype wire
